// >>> temp_serial_master.sv
// Purpose: Bus master end; makes select and the serial clock, reads words, writes commands.
// Assumes: One request at a time; start is taken only while idle.
// Notes:   The serial clock is a divided core clock and idles low.
`timescale 1ns/10ps
`default_nettype none
module temp_serial_master
  import temp_link_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Request.
  input wire logic start,
  input wire logic [4:0] rd_bits,
  input wire logic wr_en,
  input wire logic long_en,
  input wire logic [7:0] cmd1,
  input wire logic [7:0] cmd2,
  // Answer.
  output logic busy,
  output logic done,
  output logic [15:0] rd_word,
  output logic [15:0] rd_word2,
  // Link.
  temp_link_if.master link
);

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_SETUP = 3'b001,
    M_HIGH = 3'b010,
    M_LOW = 3'b011,
    M_GAP = 3'b100
  } mstate_t;

  mstate_t state_q;
  logic [7:0] tmr_q;
  logic [6:0] clk_num_q;
  logic [6:0] total_q;
  logic [6:0] next_num;
  logic [7:0] cmd1_q;
  logic [7:0] cmd2_q;
  logic [7:0] cmd_sel;
  logic sck_q;
  logic cs_n_q;
  logic sio_q;
  logic sio_oe_n_q;
  logic done_q;
  logic sio_meta_q;
  logic sio_sync_q;

  // ****************************************************************
  // Data line input synchroniser
  // ****************************************************************
  // The line comes from the other end, so it passes two flops first.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sio_meta_q <= 1'b1;
      sio_sync_q <= 1'b1;
    end else begin
      sio_meta_q <= link.sio;
      sio_sync_q <= sio_meta_q;
    end
  end

  // Next clock number and the command byte that its write phase sends.
  assign next_num = clk_num_q + 7'h01;
  assign cmd_sel = next_num[5] ? cmd2_q : cmd1_q;

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  // Select falls while the clock rests low, never on a rising edge.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= M_IDLE;
      tmr_q <= 8'h00;
      clk_num_q <= 7'h00;
      total_q <= 7'h00;
      cmd1_q <= 8'h00;
      cmd2_q <= 8'h00;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      sio_q <= 1'b0;
      sio_oe_n_q <= 1'b1;
      done_q <= 1'b0;
      rd_word <= 16'h0000;
      rd_word2 <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        M_IDLE: begin
          if (start) begin
            // Short reads end early; writes take a full or double frame.
            if (long_en) begin
              total_q <= LONG_FRAME_CLOCKS;
            end else if (wr_en) begin
              total_q <= FRAME_CLOCKS;
            end else if (rd_bits == 5'h00 || rd_bits > PHASE_CLOCKS) begin
              total_q <= {2'b00, PHASE_CLOCKS};
            end else begin
              total_q <= {2'b00, rd_bits};
            end
            cmd1_q <= cmd1;
            cmd2_q <= cmd2;
            rd_word <= 16'h0000;
            rd_word2 <= 16'h0000;
            clk_num_q <= 7'h00;
            tmr_q <= 8'h00;
            cs_n_q <= 1'b0;
            state_q <= M_SETUP;
          end
        end
        M_SETUP: begin
          if (tmr_q == 8'(CS_SETUP_CYCLES - 1)) begin
            tmr_q <= 8'h00;
            sck_q <= 1'b1;
            state_q <= M_HIGH;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        M_HIGH: begin
          if (tmr_q == 8'(SCK_HALF_CYCLES - 1)) begin
            // Read-phase bits are taken at the end of the high half.
            if (!clk_num_q[4]) begin
              if (clk_num_q[5]) begin
                rd_word2 <= {rd_word2[14:0], sio_sync_q};
              end else begin
                rd_word <= {rd_word[14:0], sio_sync_q};
              end
            end
            // Write-phase bits change on the falling edge, MSB first.
            if (next_num < total_q && next_num[4]) begin
              sio_q <= cmd_sel[3'h7 - next_num[2:0]];
              sio_oe_n_q <= 1'b0;
            end else begin
              sio_oe_n_q <= 1'b1;
            end
            tmr_q <= 8'h00;
            sck_q <= 1'b0;
            clk_num_q <= next_num;
            state_q <= M_LOW;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        M_LOW: begin
          if (tmr_q == 8'(SCK_HALF_CYCLES - 1)) begin
            tmr_q <= 8'h00;
            if (clk_num_q == total_q) begin
              cs_n_q <= 1'b1;
              sio_oe_n_q <= 1'b1;
              state_q <= M_GAP;
            end else begin
              sck_q <= 1'b1;
              state_q <= M_HIGH;
            end
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        M_GAP: begin
          if (tmr_q == 8'(CS_RELEASE_CYCLES - 1)) begin
            tmr_q <= 8'h00;
            done_q <= 1'b1;
            state_q <= M_IDLE;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        default: begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  // Link pins and answer strobes.
  assign link.cs_n = cs_n_q;
  assign link.serial_clock = sck_q;
  assign link.sio_m_o = sio_q;
  assign link.sio_m_oe_n = sio_oe_n_q;
  assign busy = (state_q != M_IDLE);
  assign done = done_q;

endmodule
`default_nettype wire

// >>> temp_link_pkg.sv
// Purpose: Shared constants for the three-wire temperature sensor link.
// Assumes: Core clock of 40 MHz; link clock made by the master end.
// Notes:   Times are kept in ns and converted to core clock cycles here.
`default_nettype none
package temp_link_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  // Least serial clock period; the half period rounds up to whole cycles.
  localparam int unsigned SCK_PERIOD_NS = 160;
  localparam int unsigned SCK_HALF_CYCLES = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least select-low to first rising clock set-up time.
  localparam int unsigned CS_SETUP_NS = 100;
  localparam int unsigned CS_SETUP_CYCLES = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least time that select stays high between frames (data line release).
  localparam int unsigned CS_RELEASE_NS = 200;
  localparam int unsigned CS_RELEASE_CYCLES = (CS_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Time that one temperature conversion takes.
  localparam int unsigned CONV_TIME_NS = 300000000;
  localparam int unsigned CONV_CYCLES_DFLT = CONV_TIME_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned TEMP_BITS = 14;
  localparam int unsigned CMD_BITS = 8;
  localparam logic [6:0] FRAME_CLOCKS = 7'h20;
  localparam logic [6:0] LONG_FRAME_CLOCKS = 7'h40;
  localparam logic [4:0] PHASE_CLOCKS = 5'h10;
  localparam logic [3:0] CMD_FULL = 4'h8;

  // ****************************************************************
  // Commands and fixed words
  // ****************************************************************
  localparam logic [7:0] CMD_SHUTDOWN = 8'hff;
  localparam logic [7:0] CMD_CONVERT = 8'h00;
  localparam logic [1:0] TAIL_BITS = 2'h3;
  // Word sent before the first conversion has finished.
  localparam logic [15:0] POWERUP_WORD = 16'h0000;
  // Identity word sent in shutdown; value is arbitrary.
  localparam logic [15:0] ID_WORD_DFLT = 16'h5a3f;

endpackage
`default_nettype wire

// >>> temp_link_if.sv
// Purpose: Three-wire link between the serial master and the sensor.
// Assumes: Data line has a pull-up; it reads high when nobody drives.
// Notes:   Enables are active low; the line level is resolved here.
`timescale 1ns/10ps
`default_nettype none
interface temp_link_if;
  // Select and clock, both driven by the master.
  logic cs_n;
  logic serial_clock;
  // Master drive of the data line.
  logic sio_m_o;
  logic sio_m_oe_n;
  // Sensor drive of the data line.
  logic sio_d_o;
  logic sio_d_oe_n;
  // Resolved line level.
  logic sio;

  // The line follows whichever end drives it, else the pull-up.
  assign sio = !sio_m_oe_n ? sio_m_o : (!sio_d_oe_n ? sio_d_o : 1'b1);

  modport master (output cs_n, output serial_clock, output sio_m_o, output sio_m_oe_n, input sio);
  modport device (input cs_n, input serial_clock, output sio_d_o, output sio_d_oe_n, input sio);
endinterface
`default_nettype wire

// >>> temp_sensor_serial_slave.sv
// Purpose: Sensor end; converts temperature samples and serves them over the three-wire link.
// Assumes: reset_n stands for the supply crossing its power-up threshold.
// Notes:   The link logic runs on the serial clock; conversion runs on core_clk.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Powers up converting; first word not valid.
// - Supply-threshold reset restores all defaults.
// - Out on falling edge, in on rising.
// - Frame: 16 transmit then 16 receive clocks.
// - Data line released while select is high.
// - Master lowers select, not on rising clock.
// - First bit appears at select fall.
// - Select may rise early during transmit.
// - New result loaded only after select high.
// - Receive starts after clock 16, lasts 16.
// - Last eight received bits form command.
// - All ones shuts down, zeros converts.
// - Master sends only all-ones or all-zeros.
// - Long frame reads identity then resumes.
// - Master waits one conversion after resuming.
// - Result has 13 magnitude bits plus sign.
// - Word is temperature in 15:2, ones below.
// - Most significant bit is sent first.
// - Shutdown sends fixed identity word.
module temp_sensor_serial_slave
  import temp_link_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DFLT,
  parameter logic [15:0] ID_WORD = ID_WORD_DFLT
)
(
  // Core clock and power-up reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Sensing front end.
  input wire logic [TEMP_BITS-1:0] temp_code,
  // Status.
  output logic conv_done,
  output logic shutdown_o,
  // Link.
  temp_link_if.device link
);

  localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Link domain.
  logic frame_rst_n;
  logic [4:0] fall_cnt_q;
  logic [4:0] rise_cnt_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_bits_q;
  logic [7:0] rx_byte_d;
  logic [3:0] rx_bits_d;
  logic mode_q;
  logic tx_phase;
  logic [15:0] word_sel;
  // Core domain.
  logic cs_meta_q;
  logic cs_sync_q;
  logic mode_meta_q;
  logic mode_sync_q;
  logic [CNT_W-1:0] conv_cnt_q;
  logic [15:0] result_q;
  logic [15:0] tx_word_q;
  logic conv_done_q;

  // ****************************************************************
  // Link domain: bit counters
  // ****************************************************************
  // Power-up reset and a high select both clear the frame state.
  assign frame_rst_n = reset_n & ~link.cs_n;

  // Falling edges move the transmit bit pointer.
  always_ff @(negedge link.serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_cnt_q <= 5'h00;
    end else begin
      fall_cnt_q <= fall_cnt_q + 5'h01;
    end
  end

  // Rising edges count clocks for the receive phase.
  always_ff @(posedge link.serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_cnt_q <= 5'h00;
    end else begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end

  // ****************************************************************
  // Link domain: receive shifter
  // ****************************************************************
  // Next receive byte and the count of bits taken in this phase.
  always_comb begin
    rx_byte_d = {rx_sh_q[6:0], link.sio};
    if (rise_cnt_q == PHASE_CLOCKS) begin
      rx_bits_d = 4'h1;
    end else if (rx_bits_q == CMD_FULL) begin
      rx_bits_d = CMD_FULL;
    end else begin
      rx_bits_d = rx_bits_q + 4'h1;
    end
  end

  // Bits are taken on rising edges after the sixteenth clock only.
  always_ff @(posedge link.serial_clock or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rx_sh_q <= 8'h00;
      rx_bits_q <= 4'h0;
    end else if (rise_cnt_q[4]) begin
      rx_sh_q <= rx_byte_d;
      rx_bits_q <= rx_bits_d;
    end
  end

  // ****************************************************************
  // Link domain: conversion mode
  // ****************************************************************
  // Once eight bits are in, the last eight decide the mode; other codes are ignored.
  always_ff @(posedge link.serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 1'b0;
    end else if (rise_cnt_q[4] && rx_bits_d == CMD_FULL) begin
      if (rx_byte_d == CMD_SHUTDOWN) begin
        mode_q <= 1'b1;
      end else if (rx_byte_d == CMD_CONVERT) begin
        mode_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Link domain: transmit path
  // ****************************************************************
  // Transmit phase is the first sixteen clocks of each thirty-two.
  assign tx_phase = ~fall_cnt_q[4];

  // Shutdown swaps the temperature word for the identity word.
  assign word_sel = mode_q ? ID_WORD : tx_word_q;

  // Bit 15 leads; it shows as soon as select falls.
  assign link.sio_d_o = word_sel[4'hf - fall_cnt_q[3:0]];

  // The line is driven only while selected and transmitting.
  assign link.sio_d_oe_n = link.cs_n | ~tx_phase;

  // ****************************************************************
  // Core domain: synchronisers
  // ****************************************************************
  // Select and mode each pass two flops before core logic reads them.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      mode_meta_q <= 1'b0;
      mode_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= link.cs_n;
      cs_sync_q <= cs_meta_q;
      mode_meta_q <= mode_q;
      mode_sync_q <= mode_meta_q;
    end
  end

  // ****************************************************************
  // Core domain: converter
  // ****************************************************************
  // Conversions run back to back unless shut down.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= '0;
      conv_done_q <= 1'b0;
      result_q <= POWERUP_WORD;
    end else if (mode_sync_q) begin
      conv_cnt_q <= '0;
      conv_done_q <= 1'b0;
    end else if (conv_cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
      conv_cnt_q <= '0;
      conv_done_q <= 1'b1;
      // Sign plus 13 magnitude bits, then two fixed ones.
      result_q <= {temp_code, TAIL_BITS};
    end else begin
      conv_cnt_q <= conv_cnt_q + CNT_W'(1);
      conv_done_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Core domain: output word
  // ****************************************************************
  // The served word only changes while select is high, so it holds steady
  // for the link logic through a frame; a conversion that ends mid-frame
  // waits for select to rise.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_word_q <= POWERUP_WORD;
    end else if (cs_sync_q) begin
      tx_word_q <= result_q;
    end
  end

  assign conv_done = conv_done_q;
  assign shutdown_o = mode_sync_q;

endmodule
`default_nettype wire

// >>> temp_link_assertions.sv
// Purpose: Checks the wire behaviour of the three-wire temperature link.
// Assumes: Both ends and the serial clock change only at core_clk edges.
// Notes:   Everything is sampled on core_clk.
`timescale 1ns/10ps
`default_nettype none
module temp_link_assertions (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset_n,
  // Link.
  input wire logic cs_n,
  input wire logic serial_clock,
  input wire logic sio_m_o,
  input wire logic sio_m_oe_n,
  input wire logic sio_d_o,
  input wire logic sio_d_oe_n,
  input wire logic sio
);
  // ****************************************
  // Falling clock count
  // ****************************************
  logic sclk_q;
  logic [4:0] fall_q;
  logic [4:0] fall_now;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // Counts falling serial clocks in a frame; cleared while select is high.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      fall_q <= 5'h00;
    end else begin
      sclk_q <= serial_clock;
      fall_q <= cs_n ? 5'h00 : fall_now;
    end
  end

  // Count including a fall seen at this edge.
  assign fall_now = fall_q + {4'h0, sclk_q & ~serial_clock};

  // ****************************************
  // Properties
  // ****************************************
  sequence s_high_half;
    serial_clock [*4];
  endsequence
  sequence s_low_half;
    !serial_clock [*4];
  endsequence
  sequence s_held_bit;
    ($stable(sio) && serial_clock) [*4];
  endsequence
  property p_release; cs_n |-> sio_d_oe_n; endproperty
  property p_first_bit; $fell(cs_n) |-> !sio_d_oe_n; endproperty
  property p_phase; !cs_n |-> (sio_d_oe_n == fall_now[4]); endproperty
  property p_out_edge; $changed(sio_d_o) && !sio_d_oe_n && !$fell(cs_n) |-> $fell(serial_clock); endproperty
  property p_in_hold; $rose(serial_clock) && !sio_m_oe_n |-> s_held_bit; endproperty
  property p_no_clash; !(!sio_m_oe_n && !sio_d_oe_n); endproperty
  property p_cs_setup; $fell(cs_n) |-> s_low_half; endproperty
  property p_half; $rose(serial_clock) |-> s_high_half ##1 s_low_half; endproperty
  property p_clk_in_frame; $rose(serial_clock) |-> !cs_n; endproperty
  property p_cs_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_release: assert property (p_release) else $error("sensor drives data with select high");
  a_first_bit: assert property (p_first_bit) else $error("first bit not driven at select fall");
  a_phase: assert property (p_phase) else $error("sensor drive outside transmit phase");
  a_out_edge: assert property (p_out_edge) else $error("sensor data moved off a falling edge");
  a_in_hold: assert property (p_in_hold) else $error("master data moved while clock high");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the data line");
  a_cs_setup: assert property (p_cs_setup) else $error("clock rose too soon after select fall");
  a_half: assert property (p_half) else $error("serial clock half period too short");
  a_clk_in_frame: assert property (p_clk_in_frame) else $error("serial clock outside a frame");
  a_cs_gap: assert property (p_cs_gap) else $error("select high time too short");
endmodule
`default_nettype wire

// >>> temp_sensor_serial_slave_test.sv
// Purpose: Runs the master end against the sensor end and checks the words.
// Assumes: Short conversion time so several conversions fit in the run.
// Notes:   Outputs are judged at the falling core clock edge.
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_serial_slave_test
  import temp_link_pkg::*;
;
  localparam int unsigned CONV = 200;
  localparam logic [15:0] ID = 16'h1e57; // Identity word; value is arbitrary.
  logic core_clk = 1'b0;
  logic reset_n = 1'b1;
  logic start = 1'b0;
  logic [4:0] rd_bits = 5'h10;
  logic wr_en = 1'b0;
  logic long_en = 1'b0;
  logic [7:0] cmd1 = 8'h00;
  logic [7:0] cmd2 = 8'h00;
  logic [13:0] temp_code = 14'h0000;
  logic busy, done, conv_done, shutdown_o;
  logic [15:0] rd_word, rd_word2;
  int mismatches = 0;
  int n_tests = 0;

  // ****************************************
  // Design and checker
  // ****************************************
  temp_link_if temp_link_if_inst ();
  temp_serial_master temp_serial_master_inst (.core_clk(core_clk), .reset_n(reset_n), .start(start),
    .rd_bits(rd_bits), .wr_en(wr_en), .long_en(long_en), .cmd1(cmd1), .cmd2(cmd2), .busy(busy),
    .done(done), .rd_word(rd_word), .rd_word2(rd_word2), .link(temp_link_if_inst.master));
  temp_sensor_serial_slave #(.CONV_CYCLES(CONV), .ID_WORD(ID)) temp_sensor_serial_slave_inst (
    .core_clk(core_clk), .reset_n(reset_n), .temp_code(temp_code), .conv_done(conv_done),
    .shutdown_o(shutdown_o), .link(temp_link_if_inst.device));
  temp_link_assertions temp_link_assertions_inst (.core_clk(core_clk), .reset_n(reset_n),
    .cs_n(temp_link_if_inst.cs_n), .serial_clock(temp_link_if_inst.serial_clock),
    .sio_m_o(temp_link_if_inst.sio_m_o), .sio_m_oe_n(temp_link_if_inst.sio_m_oe_n),
    .sio_d_o(temp_link_if_inst.sio_d_o), .sio_d_oe_n(temp_link_if_inst.sio_d_oe_n),
    .sio(temp_link_if_inst.sio));

  // Core clock of 25 ns.
  always #12.5 core_clk = ~core_clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Holds reset low for 16 cycles.
  task automatic apply_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  // Runs one master request and waits for its completion pulse.
  task automatic frame(input logic [4:0] n, input logic w, input logic l, input logic [7:0] c1,
                       input logic [7:0] c2);
    int k;
    @(posedge core_clk);
    rd_bits <= n;
    wr_en <= w;
    long_en <= l;
    cmd1 <= c1;
    cmd2 <= c2;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    k = 0;
    @(negedge core_clk);
    check1("frame busy", 1'b1, busy);
    while (done !== 1'b1 && k < 1000) begin
      @(negedge core_clk);
      k++;
    end
    check1("frame done", 1'b1, done);
  endtask
  // Waits for the end of a conversion and the word reload behind it.
  task automatic wait_conv();
    int k;
    k = 0;
    // Skip the edge of the call, so a pulse racing with it is not taken.
    @(negedge core_clk);
    while (conv_done !== 1'b1 && k < 1000) begin
      @(negedge core_clk);
      k++;
    end
    check1("conversion end", 1'b1, conv_done);
    repeat (6) @(negedge core_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup();
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("power-up word", 16'h0000, rd_word);
    check1("power-up mode", 1'b0, shutdown_o);
    $display("test power-up done");
  endtask
  task automatic t_temp();
    @(posedge core_clk);
    temp_code <= 14'h2c81;
    wait_conv();
    wait_conv();
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("temperature word", {14'h2c81, 2'b11}, rd_word);
    frame(5'h05, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("short read", {11'h000, 5'h16}, rd_word);
    $display("test temperature done");
  endtask
  task automatic t_mid_conv();
    wait_conv();
    @(posedge core_clk);
    temp_code <= 14'h0d05;
    repeat (100) @(negedge core_clk);
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("word across conversion", {14'h2c81, 2'b11}, rd_word);
    wait_conv();
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("word after select high", {14'h0d05, 2'b11}, rd_word);
    $display("test mid-conversion done");
  endtask
  task automatic t_long();
    frame(5'h10, 1'b0, 1'b1, 8'hff, 8'h00);
    check16("long frame first word", {14'h0d05, 2'b11}, rd_word);
    check16("long frame identity", ID, rd_word2);
    check1("mode after resume", 1'b0, shutdown_o);
    // A new sample shows only if a full conversion ran after the resume.
    @(posedge core_clk);
    temp_code <= 14'h3b3c;
    wait_conv();
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("word after resume", {14'h3b3c, 2'b11}, rd_word);
    $display("test long frame done");
  endtask
  task automatic t_shutdown();
    frame(5'h10, 1'b1, 1'b0, 8'hff, 8'h00);
    check1("mode after shutdown", 1'b1, shutdown_o);
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("identity word", ID, rd_word);
    apply_reset();
    @(negedge core_clk);
    check1("mode after reset", 1'b0, shutdown_o);
    frame(5'h10, 1'b0, 1'b0, 8'h00, 8'h00);
    check16("word after reset", 16'h0000, rd_word);
    $display("test shutdown done");
  endtask

  // Main sequence.
  initial begin
    // A real falling edge at time zero clears flops whose clock is still idle.
    reset_n <= 1'b0;
    apply_reset();
    t_powerup();
    t_temp();
    t_mid_conv();
    t_long();
    t_shutdown();
    report_and_stop();
  end

  // Watchdog far beyond the expected run of some 2700 cycles.
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    $display("ERROR watchdog expected end seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
